// ### design/rocf_pkg.sv
// package: register map, field layout, resets and types for the output mode configuration block
package rocf_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_STAGE1_FUNC = 8'h00;
    localparam logic [7:0] OFS_STAGE2_FUNC = 8'h04;
    localparam logic [7:0] OFS_STAGE3_FUNC = 8'h08;
    localparam logic [7:0] OFS_STAGE4_FUNC = 8'h0c;
    localparam logic [7:0] OFS_PULSE_MODE = 8'h10;
    localparam logic [7:0] OFS_TRIP_IND_SRC = 8'h14;
    localparam logic [7:0] OFS_CONTROL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_INDICATION = 8'h28;
    localparam logic [7:0] OFS_PULSE_LEN = 8'h2c;
    localparam logic [7:0] OFS_CHECKSUM = 8'h30;

    // reset values
    localparam logic [7:0] RST_STAGE_FUNC = 8'h01;
    localparam logic [7:0] RST_PULSE_MODE = 8'hff;
    localparam logic [7:0] RST_TRIP_IND_SRC = 8'h0a;
    localparam logic [15:0] RST_PULSE_LEN = 16'h00fa;

    // stage function field positions
    localparam int FUNC_FREQ_BIT = 0;
    localparam int FUNC_BOTH_BIT = 1;
    localparam int FUNC_RATE_BIT = 2;
    localparam int FUNC_LATCH_BIT = 3;

    // control register field positions
    localparam int CTL_SETTING_BIT = 0;
    localparam int CTL_RECOV_EN_BIT = 1;
    localparam int CTL_IND_RESET_BIT = 2;
    localparam int CTL_SEL_LSB = 4;
    localparam int CTL_SWITCH_LSB = 8;

    // pulse length time base: 1 us per tick at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        ROCF_OFF,
        ROCF_FREQ,
        ROCF_BOTH,
        ROCF_RATE
    } rocf_mode_type;

    typedef struct packed {
        logic [3:0] start;
        logic [3:0] trip;
    } rocf_stage_type;

    typedef struct packed {
        logic [3:0] freq_pickup;
        logic [3:0] rate_pickup;
    } rocf_meas_type;

endpackage : rocf_pkg

// ### design/rocf_top.sv
// output mode configuration: switchgroups, output pulse shaping, indicator, display data
//
// Notes on behaviour
// - switches 1,2,3 pick freq, both, rate
// - switch 4 low: start code clears
// - switch 4 high: start code stays latched
// - mode bit high: output follows stage
// - mode bit low: output pulses then drops
// - mode bits alternate start/trip, default all ones
// - selected output lights shared trip indicator
// - selected output starts recovery when enabled
// - select bits alternate start/trip, default trips 1,2
// - setting mode shows switch number and position
// - normal service shows only group checksums
// - checksum is weighted sum of set switches
// - trip code and indicator latch until reset
`timescale 1ns/1ps
`default_nettype none

module rocf_top
    import rocf_pkg::*;
#(
    parameter int PULSE_W = 16
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // protection stage inputs
    input wire rocf_meas_type i_meas,
    input wire rocf_stage_type i_stage_trip,
    input wire logic i_ind_reset,
    // outputs
    output rocf_stage_type o_outputs,
    output logic o_trip_led,
    output logic o_recovery_start,
    output logic [3:0] o_disp_switch_num,
    output logic o_disp_switch_pos,
    output logic [7:0] o_disp_checksum,
    output logic o_irq
);

    logic [7:0] func_reg [4];
    logic [7:0] pulse_mode_reg;
    logic [7:0] trip_src_reg;
    logic [10:0] control_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic [PULSE_W-1:0] pulse_len_reg;
    logic [3:0] start_code_reg;
    logic [3:0] trip_code_reg;
    logic trip_led_reg;
    logic recovery_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] tick_cnt_reg;
    logic tick;
    logic [7:0] raw_out;
    logic [7:0] out_reg;
    logic [7:0] prev_raw_reg;
    logic [7:0] prev_out_reg;
    logic [PULSE_W-1:0] pulse_cnt_reg [8];
    rocf_mode_type mode [4];
    logic [3:0] start_raw;
    logic wr_en;
    logic rd_en;
    logic [7:0] ind_fire;
    logic [7:0] irq_set;
    logic [7:0] sel_group;
    logic [2:0] sel_switch;
    logic ind_clr;

    assign wr_en = i_avs_write && !ack_reg;
    assign rd_en = i_avs_read && !ack_reg;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
    assign o_avs_readdata = rdata_reg;

    // one wait state, then accept
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
    end

    // configuration register writes
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            for (int k = 0; k < 4; k++)
                func_reg[k] <= RST_STAGE_FUNC;
            pulse_mode_reg <= RST_PULSE_MODE;
            trip_src_reg <= RST_TRIP_IND_SRC;
            control_reg <= 8'h00;
            irq_mask_reg <= 8'h00;
            pulse_len_reg <= PULSE_W'(RST_PULSE_LEN);
        end
        else if (wr_en && i_avs_byteenable[0])
        begin
            if (i_avs_address == OFS_STAGE1_FUNC)
                func_reg[0] <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_STAGE2_FUNC)
                func_reg[1] <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_STAGE3_FUNC)
                func_reg[2] <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_STAGE4_FUNC)
                func_reg[3] <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_PULSE_MODE)
                pulse_mode_reg <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_TRIP_IND_SRC)
                trip_src_reg <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_CONTROL)
                control_reg <= i_avs_writedata[10:0] & ~(11'h001 << CTL_IND_RESET_BIT);
            else if (i_avs_address == OFS_IRQ_MASK)
                irq_mask_reg <= i_avs_writedata[7:0];
            else if (i_avs_address == OFS_PULSE_LEN)
                pulse_len_reg <= i_avs_writedata[PULSE_W-1:0];
        end
    end

    // read mux
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            rdata_reg <= 32'h0000_0000;
        else if (rd_en)
        begin
            if (i_avs_address == OFS_STAGE1_FUNC)
                rdata_reg <= {24'h00_0000, func_reg[0]};
            else if (i_avs_address == OFS_STAGE2_FUNC)
                rdata_reg <= {24'h00_0000, func_reg[1]};
            else if (i_avs_address == OFS_STAGE3_FUNC)
                rdata_reg <= {24'h00_0000, func_reg[2]};
            else if (i_avs_address == OFS_STAGE4_FUNC)
                rdata_reg <= {24'h00_0000, func_reg[3]};
            else if (i_avs_address == OFS_PULSE_MODE)
                rdata_reg <= {24'h00_0000, pulse_mode_reg};
            else if (i_avs_address == OFS_TRIP_IND_SRC)
                rdata_reg <= {24'h00_0000, trip_src_reg};
            else if (i_avs_address == OFS_CONTROL)
                rdata_reg <= {21'h0_0000, control_reg};
            else if (i_avs_address == OFS_STATUS)
                rdata_reg <= {22'h00_0000, recovery_reg, trip_led_reg, out_reg};
            else if (i_avs_address == OFS_IRQ_STATUS)
                rdata_reg <= {24'h00_0000, irq_status_reg};
            else if (i_avs_address == OFS_IRQ_MASK)
                rdata_reg <= {24'h00_0000, irq_mask_reg};
            else if (i_avs_address == OFS_INDICATION)
                rdata_reg <= {16'h0000, 4'h0, trip_code_reg, 4'h0, start_code_reg};
            else if (i_avs_address == OFS_PULSE_LEN)
                rdata_reg <= 32'(pulse_len_reg);
            else if (i_avs_address == OFS_CHECKSUM)
                rdata_reg <= {24'h00_0000, o_disp_checksum};
            else
                rdata_reg <= 32'h0000_0000;
        end
    end

    // stage pickup from function select; switches 5-8 unused
    generate
        for (genvar s = 0; s < 4; s++)
        begin : g_stage
            always_comb
            begin
                if (func_reg[s][FUNC_FREQ_BIT])
                    mode[s] = ROCF_FREQ;
                else if (func_reg[s][FUNC_BOTH_BIT])
                    mode[s] = ROCF_BOTH;
                else if (func_reg[s][FUNC_RATE_BIT])
                    mode[s] = ROCF_RATE;
                else
                    mode[s] = ROCF_OFF;
            end
            always_comb
            begin
                case (mode[s])
                    ROCF_FREQ: start_raw[s] = i_meas.freq_pickup[s];
                    ROCF_BOTH: start_raw[s] = i_meas.freq_pickup[s] && i_meas.rate_pickup[s];
                    ROCF_RATE: start_raw[s] = i_meas.rate_pickup[s];
                    default: start_raw[s] = 1'b0;
                endcase
            end
            // interleave: even bit start, odd bit trip
            assign raw_out[2*s] = start_raw[s];
            assign raw_out[2*s+1] = i_stage_trip.trip[s] && start_raw[s];
        end
    endgenerate

    // pulse length time base
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || tick)
            tick_cnt_reg <= 8'h00;
        else
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
    assign tick = (tick_cnt_reg == 8'(TICK_CYCLES - 1));

    // per-output continuous or pulse shaping
    generate
        for (genvar b = 0; b < 8; b++)
        begin : g_out
            always_ff @(posedge i_clk)
            begin
                if (i_sys_rst)
                begin
                    pulse_cnt_reg[b] <= '0;
                    out_reg[b] <= 1'b0;
                end
                else if (pulse_mode_reg[b])
                begin
                    out_reg[b] <= raw_out[b];
                    pulse_cnt_reg[b] <= '0;
                end
                else if (raw_out[b] && !prev_raw_reg[b])
                begin
                    out_reg[b] <= (pulse_len_reg != '0);
                    pulse_cnt_reg[b] <= pulse_len_reg;
                end
                else if (!raw_out[b] || pulse_cnt_reg[b] == '0)
                begin
                    out_reg[b] <= 1'b0;
                    pulse_cnt_reg[b] <= '0;
                end
                else if (tick)
                begin
                    pulse_cnt_reg[b] <= pulse_cnt_reg[b] - PULSE_W'(1);
                    if (pulse_cnt_reg[b] == PULSE_W'(1))
                        out_reg[b] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            prev_raw_reg <= 8'h00;
            prev_out_reg <= 8'h00;
        end
        else
        begin
            prev_raw_reg <= raw_out;
            prev_out_reg <= out_reg;
        end
    end

    assign o_outputs.start = {out_reg[6], out_reg[4], out_reg[2], out_reg[0]};
    assign o_outputs.trip = {out_reg[7], out_reg[5], out_reg[3], out_reg[1]};
    assign ind_fire = out_reg & trip_src_reg;
    assign ind_clr = i_ind_reset || (wr_en && i_avs_address == OFS_CONTROL && i_avs_writedata[CTL_IND_RESET_BIT]);

    // start and trip indication codes
    generate
        for (genvar s = 0; s < 4; s++)
        begin : g_code
            always_ff @(posedge i_clk)
            begin
                if (i_sys_rst)
                begin
                    start_code_reg[s] <= 1'b0;
                    trip_code_reg[s] <= 1'b0;
                end
                else
                begin
                    if (raw_out[2*s+1])
                        trip_code_reg[s] <= 1'b1;
                    else if (ind_clr)
                        trip_code_reg[s] <= 1'b0;
                    if (raw_out[2*s+1])
                        start_code_reg[s] <= 1'b0;
                    else if (start_raw[s])
                        start_code_reg[s] <= 1'b1;
                    else if (ind_clr || !func_reg[s][FUNC_LATCH_BIT])
                        start_code_reg[s] <= 1'b0;
                    // latched otherwise
                end
            end
        end
    endgenerate

    // shared trip indicator and recovery start; a new event wins over a clear
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            trip_led_reg <= 1'b0;
        else if (|ind_fire)
            trip_led_reg <= 1'b1;
        else if (ind_clr)
            trip_led_reg <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            recovery_reg <= 1'b0;
        else
            recovery_reg <= (|(ind_fire & ~prev_out_reg)) && control_reg[CTL_RECOV_EN_BIT];
    end
    assign o_trip_led = trip_led_reg;
    assign o_recovery_start = recovery_reg;

    // interrupts: unshaped raw_out rising edges, write one to clear, set wins
    assign irq_set = raw_out & ~prev_raw_reg;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            irq_status_reg <= 8'h00;
        else if (wr_en && i_avs_address == OFS_IRQ_STATUS && i_avs_byteenable[0])
            irq_status_reg <= (irq_status_reg & ~i_avs_writedata[7:0]) | irq_set;
        else
            irq_status_reg <= irq_status_reg | irq_set;
    end
    assign o_irq = |(irq_status_reg & irq_mask_reg);

    // display: group and switch chosen by control register
    assign sel_group = {5'h00, control_reg[CTL_SEL_LSB +: 3]};
    assign sel_switch = control_reg[CTL_SWITCH_LSB +: 3];
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_disp_checksum <= RST_STAGE_FUNC;
            o_disp_switch_num <= 4'h0;
            o_disp_switch_pos <= 1'b0;
        end
        else
        begin
            // weighted sum equals the group value
            if (sel_group < 8'h04)
                o_disp_checksum <= func_reg[sel_group[1:0]];
            else if (sel_group == 8'h04)
                o_disp_checksum <= pulse_mode_reg;
            else
                o_disp_checksum <= trip_src_reg;
            if (control_reg[CTL_SETTING_BIT])
            begin
                o_disp_switch_num <= {1'b0, sel_switch} + 4'h1;
                o_disp_switch_pos <= o_disp_checksum[sel_switch];
            end
            else
            begin
                o_disp_switch_num <= 4'h0;
                o_disp_switch_pos <= 1'b0;
            end
        end
    end

endmodule : rocf_top

`default_nettype wire

// ### verification/rocf_top_sva.sv
// port assertions for the output mode configuration block
`timescale 1ns/1ps
`default_nettype none
module rocf_top_sva
    import rocf_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // register bus
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // stage side
    input wire rocf_meas_type i_meas,
    input wire logic i_ind_reset,
    input wire rocf_stage_type o_outputs,
    input wire logic o_trip_led,
    input wire logic o_recovery_start,
    input wire logic [7:0] o_disp_checksum
);
    default clocking cb @(posedge i_clk);
    endclocking

    wait_first_a: assert property (disable iff (i_sys_rst)
        $rose(i_avs_read) || $rose(i_avs_write) |-> o_avs_waitrequest) else $error("no wait state");
    ack_second_a: assert property (disable iff (i_sys_rst)
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) ##1 (i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("no answer in second cycle");
    unmapped_zero_a: assert property (disable iff (i_sys_rst)
        i_avs_read && !o_avs_waitrequest && i_avs_address > 8'h33 |-> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    narrow_reg_a: assert property (disable iff (i_sys_rst)
        i_avs_read && !o_avs_waitrequest && i_avs_address < 8'h1c |-> o_avs_readdata[31:8] == 24'h00_0000)
        else $error("upper bits of group set");
    led_hold_a: assert property (disable iff (i_sys_rst)
        o_trip_led && !i_ind_reset && !i_avs_write |=> o_trip_led) else $error("indicator dropped");
    led_cause_a: assert property (disable iff (i_sys_rst)
        $rose(o_trip_led) |-> $past(o_outputs) != 8'h00) else $error("indicator without output");
    rec_pulse_a: assert property (disable iff (i_sys_rst)
        o_recovery_start |=> !o_recovery_start) else $error("recovery start too long");
    rec_cause_a: assert property (disable iff (i_sys_rst)
        o_recovery_start |-> $past(o_outputs) != 8'h00) else $error("recovery start without output");
    out_cause_a: assert property (disable iff (i_sys_rst)
        o_outputs != 8'h00 |-> $past(i_meas) != 8'h00 || $past(i_meas, 2) != 8'h00 || $past(i_meas, 3) != 8'h00)
        else $error("output without pickup");
    reset_state_a: assert property (i_sys_rst |=> o_disp_checksum == 8'h01 && o_outputs == 8'h00 && !o_trip_led)
        else $error("bad state after reset");
endmodule : rocf_top_sva

bind rocf_top rocf_top_sva i_rocf_top_sva (.*);
`default_nettype wire

// ### verification/tb_rocf_top.sv
// self-checking testbench for the output mode configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rocf_top;
    import rocf_pkg::*;
    logic i_clk = 0;
    logic i_sys_rst = 1;
    logic [7:0] adr = 8'h00;
    logic rd = 0;
    logic wr = 0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic wq;
    rocf_meas_type meas = '0;
    rocf_stage_type trp = '0;
    logic ind_rst = 0;
    rocf_stage_type outs;
    logic led, rec, irq, irq0, pos;
    logic [3:0] snum;
    logic [7:0] csum;
    logic rec_seen = 0;
    logic [31:0] q;
    logic [31:0] seed = 32'h0000_003d;
    logic [7:0] mdl [0:5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'hff, 8'h0a};
    logic [7:0] tf [0:6] = '{8'h01, 8'h01, 8'h04, 8'h04, 8'h02, 8'h00, 8'hf1};
    logic [7:0] tm [0:6] = '{8'h10, 8'h01, 8'h01, 8'h10, 8'h11, 8'h11, 8'h10};
    logic te [0:6] = '{1, 0, 1, 0, 1, 0, 1};
    int error_cnt = 0;
    int checked = 0;
    int cyc_cnt = 0;

    rocf_top i_rocf_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_meas(meas), .i_stage_trip(trp), .i_ind_reset(ind_rst), .o_outputs(outs),
        .o_trip_led(led), .o_recovery_start(rec), .o_disp_switch_num(snum), .o_disp_switch_pos(pos),
        .o_disp_checksum(csum), .o_irq(irq));

    always #2 i_clk = ~i_clk;
    always @(negedge i_clk) if (rec) rec_seen = 1;
    always @(posedge i_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc

    // bus cycle: request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        @(posedge i_clk);
        while (wq)
            @(posedge i_clk);
        q = rdat;
        rd <= 0;
        wr <= 0;
        @(posedge i_clk);
    endtask : acc

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        acc(1, a, d);
        if (a < 8'h18) mdl[a[4:2]] = d[7:0];
    endtask : wreg

    initial
    begin
        cyc(5);
        i_sys_rst <= 0;
        cyc(1);
        for (int i = 0; i < 6; i++)
        begin
            acc(0, 8'(i * 4), 32'h0000_0000);
            `CHK(q, {24'h00_0000, mdl[i]})
        end
        acc(0, 8'h40, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        $display("test reset values done");
        for (int i = 0; i < 7; i++)
        begin
            wreg(OFS_STAGE1_FUNC, {24'h00_0000, tf[i]});
            meas <= tm[i];
            cyc(8);
            `CHK(outs.start[0], te[i])
            meas <= '0;
            cyc(8);
        end
        $display("test function modes done");
        for (int i = 0; i < 2; i++)
        begin
            wreg(OFS_STAGE1_FUNC, i ? 32'h0000_0009 : 32'h0000_0001);
            meas <= 8'h10;
            cyc(8);
            meas <= 8'h00;
            cyc(8);
            acc(0, OFS_INDICATION, 32'h0000_0000);
            `CHK(q[0], 1'(i))
        end
        ind_rst <= 1;
        cyc(2);
        ind_rst <= 0;
        cyc(2);
        acc(0, OFS_INDICATION, 32'h0000_0000);
        `CHK(q[0], 1'b0)
        $display("test start code latch done");
        wreg(OFS_STAGE1_FUNC, 32'h0000_0001);
        wreg(OFS_PULSE_LEN, 32'h0000_0002);
        for (int i = 0; i < 2; i++)
        begin
            wreg(OFS_PULSE_MODE, i ? 32'h0000_00fe : 32'h0000_00fd);
            meas <= 8'h10;
            cyc(20);
            `CHK(outs.start[0], 1'b1)
            cyc(600);
            `CHK(outs.start[0], 1'(1 - i))
            meas <= 8'h00;
            cyc(8);
        end
        wreg(OFS_PULSE_MODE, 32'h0000_00ff);
        $display("test pulse mode done");
        wreg(OFS_IRQ_STATUS, 32'h0000_00ff);
        wreg(OFS_CONTROL, 32'h0000_0002);
        rec_seen = 0;
        meas <= 8'h10;
        trp.trip <= 4'h1;
        cyc(10);
        `CHK(led, 1'b1)
        `CHK(rec_seen, 1'b1)
        `CHK(outs, 8'h11)
        meas <= 8'h00;
        trp <= '0;
        cyc(10);
        `CHK(led, 1'b1)
        acc(0, OFS_INDICATION, 32'h0000_0000);
        `CHK(q[8], 1'b1)
        acc(0, OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK(q, 32'h0000_0003)
        wreg(OFS_IRQ_MASK, 32'h0000_0000);
        irq0 = irq;
        wreg(OFS_IRQ_MASK, 32'h0000_00ff);
        `CHK(irq0 ^ irq, 1'b1)
        wreg(OFS_IRQ_STATUS, 32'h0000_00ff);
        `CHK(irq, 1'b0)
        ind_rst <= 1;
        cyc(2);
        ind_rst <= 0;
        cyc(2);
        `CHK(led, 1'b0)
        wreg(OFS_TRIP_IND_SRC, 32'h0000_0000);
        rec_seen = 0;
        meas <= 8'h10;
        trp.trip <= 4'h1;
        cyc(10);
        `CHK(led, 1'b0)
        `CHK(rec_seen, 1'b0)
        meas <= 8'h00;
        trp <= '0;
        cyc(10);
        $display("test trip indicator done");
        for (int g = 0; g < 6; g++)
        begin
            seed = xs(seed);
            wreg(8'(g * 4), {24'h00_0000, seed[7:0]});
            wreg(OFS_CONTROL, 32'(g << 4));
            cyc(4);
            `CHK(csum, mdl[g])
            `CHK(snum, 4'h0)
            acc(0, OFS_CHECKSUM, 32'h0000_0000);
            `CHK(q, {24'h00_0000, mdl[g]})
            wreg(OFS_CONTROL, {21'h0_0000, seed[10:8], 1'b0, 3'(g), 4'h1});
            cyc(4);
            `CHK(snum, 4'(seed[10:8]) + 4'h1)
            `CHK(pos, mdl[g][seed[10:8]])
        end
        $display("test checksums done");
        give_verdict();
    end
endmodule : tb_rocf_top
`default_nettype wire
